// ### design/ssop_top.sv
// Purpose: synchronous serial output port on borrowed segment pins
// Assumes: memory read data valid the cycle after MEM_RD
// Notes: PASS_START, DISPLAY_ENABLE and segment drive share REF_CLK
`timescale 1ns/1ps
module ssop_top (
    input  wire logic        REF_CLK,
    input  wire logic        SRST,
    input  wire logic [15:0] AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        PASS_START,
    input  wire logic        DISPLAY_ENABLE,
    input  wire logic [3:0]  LCD_SEG_DRIVE,
    output logic [7:0]       MEM_ADDR,
    output logic             MEM_RD,
    input  wire logic [31:0] MEM_RDATA,
    output logic             SEG_PIN_A,
    output logic             SEG_PIN_B,
    output logic             SEG_PIN_C,
    output logic             SEG_PIN_D
);
    import ssop_pkg::*;
    ssop_avreq_t req;
    ssop_cfg_t   cfg;
    ssop_state_t state_reg;
    logic [7:0]  blk_beg;
    logic [7:0]  blk_end;
    logic [7:0]  status;
    logic        sclk_level;
    logic        fall_tick;
    logic        pend_reg;
    logic        active_reg;
    logic        frame_reg;
    logic        have_next_reg;
    logic        rd_dly_reg;
    logic [31:0] shift_reg;
    logic [31:0] next_word_reg;
    logic [4:0]  bit_idx_reg;
    logic [7:0]  mem_addr_reg;
    logic        mem_rd_reg;
    logic [3:0]  seg_reg;
    logic        serial_sel;
    logic        ready_sel;
    logic        start_ok;
    logic        need_load;
    logic        load;
    logic        finish;
    logic        shift_ev;
    logic        more_words;
    logic        frame_next;
    logic        sclk_pin;
    logic        data_pin;
    logic        frame_pin;
    logic        ready_pin;

    // bus request bundle
    assign req = {AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA, AVS_BYTEENABLE};

    ssop_regs u_regs (
        .clk         (REF_CLK),
        .srst        (SRST),
        .req         (req),
        .status      (status),
        .waitrequest (AVS_WAITREQUEST),
        .readdata    (AVS_READDATA),
        .cfg         (cfg),
        .blk_beg     (blk_beg),
        .blk_end     (blk_end)
    );

    ssop_sclk_gen u_sclk (
        .clk       (REF_CLK),
        .srst      (SRST),
        .fast      (cfg.fast_clock_select),
        .level     (sclk_level),
        .fall_tick (fall_tick)
    );

    // status byte
    always_comb begin
        status              = 8'h00;
        status[STAT_BUSY]   = state_reg != ST_IDLE;
        status[STAT_SERIAL] = serial_sel;
        status[STAT_PEND]   = pend_reg;
    end

    // pin ownership and sequencing terms
    assign serial_sel = cfg.port_enable & ~DISPLAY_ENABLE;
    assign ready_sel  = serial_sel & cfg.ready_pin_enable;
    assign start_ok   = pend_reg & serial_sel & (blk_end > blk_beg);
    assign need_load  = fall_tick & (~active_reg | (bit_idx_reg == 5'h0));
    assign more_words = mem_addr_reg != blk_end;
    assign finish     = (state_reg == ST_RUN) & (~serial_sel | (need_load & ~have_next_reg));
    assign load       = (state_reg == ST_RUN) & serial_sel & need_load & have_next_reg;
    assign shift_ev   = (state_reg == ST_RUN) & serial_sel & fall_tick & active_reg & (bit_idx_reg != 5'h0);

    // pass request latch, a new request beats the clear
    always_ff @(posedge REF_CLK) begin
        if (SRST)
            pend_reg <= 1'b0;
        else if (PASS_START)
            pend_reg <= 1'b1;
        else if (state_reg == ST_IDLE && (start_ok || !serial_sel))
            pend_reg <= 1'b0;
    end

    // block sequencer
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_ok)
                        state_reg <= ST_PRIME;
                end
                ST_PRIME: begin
                    if (!serial_sel)
                        state_reg <= ST_IDLE;
                    else if (have_next_reg)
                        state_reg <= ST_RUN;
                end
                ST_RUN: begin
                    if (finish)
                        state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // memory fetch, one word ahead of the shifter
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            mem_addr_reg <= 8'h00;
            mem_rd_reg   <= 1'b0;
        end else begin
            mem_rd_reg <= 1'b0;
            if (state_reg == ST_IDLE && start_ok) begin
                mem_addr_reg <= blk_beg;
                mem_rd_reg   <= 1'b1;
            end else if (load && more_words) begin
                mem_addr_reg <= mem_addr_reg + 8'h01;
                mem_rd_reg   <= 1'b1;
            end
        end
    end

    // fetched word holding register
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            rd_dly_reg    <= 1'b0;
            have_next_reg <= 1'b0;
            next_word_reg <= 32'h0;
        end else begin
            rd_dly_reg <= mem_rd_reg;
            if (rd_dly_reg && state_reg != ST_IDLE) begin
                next_word_reg <= MEM_RDATA;
                have_next_reg <= 1'b1;
            end else if (load || finish || state_reg == ST_IDLE) begin
                have_next_reg <= 1'b0;
            end
        end
    end

    // shifter, msb first, moves on the falling tick
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            shift_reg   <= 32'h0;
            bit_idx_reg <= 5'h0;
            active_reg  <= 1'b0;
        end else if (finish) begin
            bit_idx_reg <= 5'h0;
            active_reg  <= 1'b0;
        end else if (load) begin
            shift_reg   <= next_word_reg;
            bit_idx_reg <= LAST_BIT;
            active_reg  <= 1'b1;
        end else if (shift_ev) begin
            shift_reg   <= {shift_reg[30:0], 1'b0};
            bit_idx_reg <= bit_idx_reg - 5'h1;
        end
    end

    // frame boundary inside a word
    always_comb begin
        case (cfg.frame_pulse_spacing)
            SPACE_8:  frame_next = bit_idx_reg[2:0] == 3'h0;
            SPACE_16: frame_next = bit_idx_reg[3:0] == 4'h0;
            default:  frame_next = 1'b0;
        endcase
    end

    // frame pulse lasts one serial clock period
    always_ff @(posedge REF_CLK) begin
        if (SRST)
            frame_reg <= 1'b0;
        else if (finish)
            frame_reg <= 1'b0;
        else if (load)
            frame_reg <= ~active_reg | (cfg.frame_pulse_spacing != SPACE_BLOCK);
        else if (shift_ev)
            frame_reg <= frame_next;
    end

    // serial function levels
    assign sclk_pin  = sclk_level & (~cfg.clock_gate_enable | active_reg);
    assign data_pin  = active_reg & shift_reg[31];
    assign frame_pin = frame_reg ^ cfg.frame_pulse_polarity;
    assign ready_pin = active_reg ^ cfg.ready_pin_polarity;

    // pin mux, registered
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            seg_reg <= 4'h0;
        end else begin
            seg_reg[0] <= serial_sel ? sclk_pin : LCD_SEG_DRIVE[0];
            seg_reg[1] <= serial_sel ? data_pin : LCD_SEG_DRIVE[1];
            seg_reg[2] <= serial_sel ? frame_pin : LCD_SEG_DRIVE[2];
            seg_reg[3] <= ready_sel ? ready_pin : LCD_SEG_DRIVE[3];
        end
    end

    assign SEG_PIN_A = seg_reg[0];
    assign SEG_PIN_B = seg_reg[1];
    assign SEG_PIN_C = seg_reg[2];
    assign SEG_PIN_D = seg_reg[3];
    assign MEM_ADDR  = mem_addr_reg;
    assign MEM_RD    = mem_rd_reg;

    // checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);

    sequence s_fast_period;
        $rose(sclk_level) ##0 cfg.fast_clock_select [*4];
    endsequence
    sequence s_slow_period;
        $rose(sclk_level) ##0 !cfg.fast_clock_select [*6];
    endsequence
    sequence s_block_start;
        state_reg == ST_IDLE && start_ok;
    endsequence

    property p_clk_pin;
        serial_sel && !cfg.clock_gate_enable |=> SEG_PIN_A == $past(sclk_level);
    endproperty
    a_clk_pin: assert property (p_clk_pin) else $error("serial clock pin wrong");

    property p_ready_lcd;
        !ready_sel |=> SEG_PIN_D == $past(LCD_SEG_DRIVE[3]);
    endproperty
    a_ready_lcd: assert property (p_ready_lcd) else $error("ready pin not lcd");

    property p_data_pin;
        serial_sel && active_reg |=> SEG_PIN_B == $past(shift_reg[31]);
    endproperty
    a_data_pin: assert property (p_data_pin) else $error("data pin wrong");

    property p_rate_fast;
        s_fast_period |-> $rose(sclk_level);
    endproperty
    a_rate_fast: assert property (p_rate_fast) else $error("fast period wrong");

    property p_rate_slow;
        s_slow_period |-> $rose(sclk_level);
    endproperty
    a_rate_slow: assert property (p_rate_slow) else $error("slow period wrong");

    property p_gate_low;
        serial_sel && cfg.clock_gate_enable && !active_reg |=> !SEG_PIN_A;
    endproperty
    a_gate_low: assert property (p_gate_low) else $error("gated clock ran");

    property p_frame8;
        shift_ev && cfg.frame_pulse_spacing == SPACE_8 && bit_idx_reg[2:0] == 3'h0 |=> frame_reg;
    endproperty
    a_frame8: assert property (p_frame8) else $error("missing 8-bit frame");

    property p_frame_block;
        shift_ev && cfg.frame_pulse_spacing == SPACE_BLOCK |=> !frame_reg;
    endproperty
    a_frame_block: assert property (p_frame_block) else $error("extra block frame");

    property p_frame_pol;
        serial_sel && frame_reg |=> SEG_PIN_C != $past(cfg.frame_pulse_polarity);
    endproperty
    a_frame_pol: assert property (p_frame_pol) else $error("frame polarity wrong");

    property p_ready_pol;
        ready_sel && !active_reg |=> SEG_PIN_D == $past(cfg.ready_pin_polarity);
    endproperty
    a_ready_pol: assert property (p_ready_pol) else $error("ready polarity wrong");

    property p_addr_range;
        MEM_RD |-> MEM_ADDR >= blk_beg && MEM_ADDR <= blk_end;
    endproperty
    a_addr_range: assert property (p_addr_range) else $error("fetch outside block");

    property p_prime;
        s_block_start ##1 serial_sel [*3] |=> state_reg == ST_RUN;
    endproperty
    a_prime: assert property (p_prime) else $error("block did not start");

    property p_msb_first;
        load ##1 serial_sel |=> SEG_PIN_B == $past(next_word_reg[31], 2);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("msb not first");
endmodule // ssop_top

// ### design/ssop_pkg.sv
// Purpose: constants and types for the serial output port
// Assumes: 25 MHz REF_CLK, 32-bit Avalon-MM register bus
// Notes: register byte address is four times the register index
package ssop_pkg;
    // clock and serial clock rates
    localparam int         CLK_HZ      = 25_000_000;
    localparam int         SLOW_HZ     = 5_000_000;
    localparam int         FAST_HZ     = 10_000_000;
    localparam logic [2:0] SLOW_PERIOD = 3'((CLK_HZ + SLOW_HZ - 1) / SLOW_HZ);
    localparam logic [2:0] FAST_PERIOD = 3'((CLK_HZ + FAST_HZ - 1) / FAST_HZ);

    // register indices and reset values
    localparam logic [15:0] CTRL_IDX   = 16'h2070;
    localparam logic [15:0] BEG_IDX    = 16'h2071;
    localparam logic [15:0] END_IDX    = 16'h2072;
    localparam logic [15:0] STATUS_IDX = 16'h2073;
    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [7:0]  BEG_RST    = 8'h00;
    localparam logic [7:0]  END_RST    = 8'h00;

    // status bit positions
    localparam int STAT_BUSY   = 0;
    localparam int STAT_SERIAL = 1;
    localparam int STAT_PEND   = 2;

    // frame spacing codes and word length
    localparam logic [1:0] SPACE_BLOCK = 2'h0;
    localparam logic [1:0] SPACE_8     = 2'h1;
    localparam logic [1:0] SPACE_16    = 2'h2;
    localparam logic [4:0] LAST_BIT    = 5'h1F;

    // control byte, bit 7 down to bit 0
    typedef struct packed {
        logic       port_enable;
        logic       fast_clock_select;
        logic       clock_gate_enable;
        logic [1:0] frame_pulse_spacing;
        logic       frame_pulse_polarity;
        logic       ready_pin_enable;
        logic       ready_pin_polarity;
    } ssop_cfg_t;

    // one Avalon-MM request
    typedef struct packed {
        logic        read;
        logic        write;
        logic [15:0] addr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } ssop_avreq_t;

    typedef enum logic [1:0] {ST_IDLE, ST_PRIME, ST_RUN} ssop_state_t;

    // byte address matches a register index
    function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] idx);
        return addr == {idx[13:0], 2'b00};
    endfunction
endpackage

// ### design/ssop_sclk_gen.sv
// Purpose: serial clock divider with a falling-edge tick
// Assumes: periods rounded up, so the clock never runs fast
// Notes: high phase is the shorter half
`timescale 1ns/1ps
module ssop_sclk_gen (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic fast,
    output logic      level,
    output logic      fall_tick
);
    import ssop_pkg::*;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic [2:0] period;
    logic [2:0] high;

    // period select and wrap
    always_comb begin
        period   = fast ? FAST_PERIOD : SLOW_PERIOD;
        high     = period >> 1;
        cnt_next = (cnt_reg >= period - 3'h1) ? 3'h0 : cnt_reg + 3'h1;
    end

    // counter, level and tick on the first low cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg   <= 3'h0;
            level     <= 1'b1; // count zero is a high cycle, no short first period
            fall_tick <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            level     <= cnt_next < high;
            fall_tick <= cnt_next == high;
        end
    end
endmodule // ssop_sclk_gen

// ### design/ssop_regs.sv
// Purpose: Avalon-MM slave holding the port registers
// Assumes: every access answers one cycle after it is seen
// Notes: unmapped reads return zero, unmapped writes are dropped
`timescale 1ns/1ps
module ssop_regs (
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire ssop_pkg::ssop_avreq_t req,
    input  wire logic [7:0]            status,
    output logic                       waitrequest,
    output logic [31:0]                readdata,
    output ssop_pkg::ssop_cfg_t        cfg,
    output logic [7:0]                 blk_beg,
    output logic [7:0]                 blk_end
);
    import ssop_pkg::*;
    logic       live;
    logic       wr_ok;
    logic [7:0] rsel;

    assign live  = req.read | req.write;
    assign wr_ok = live & ~waitrequest & req.write & req.be[0];

    // read mux
    always_comb begin
        rsel = 8'h00;
        if (reg_hit(req.addr, CTRL_IDX))
            rsel = cfg;
        else if (reg_hit(req.addr, BEG_IDX))
            rsel = blk_beg;
        else if (reg_hit(req.addr, END_IDX))
            rsel = blk_end;
        else if (reg_hit(req.addr, STATUS_IDX))
            rsel = status;
    end

    // wait drops for exactly one cycle per request
    always_ff @(posedge clk) begin
        if (srst)
            waitrequest <= 1'b1;
        else
            waitrequest <= ~(live & waitrequest);
    end

    // read data captured with the wait drop
    always_ff @(posedge clk) begin
        if (srst)
            readdata <= 32'h0;
        else if (live & waitrequest)
            readdata <= {24'h0, rsel};
    end

    // writes land at the edge that sees wait low
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg     <= CTRL_RST;
            blk_beg <= BEG_RST;
            blk_end <= END_RST;
        end else if (wr_ok) begin
            if (reg_hit(req.addr, CTRL_IDX))
                cfg <= req.wdata[7:0];
            if (reg_hit(req.addr, BEG_IDX))
                blk_beg <= req.wdata[7:0];
            if (reg_hit(req.addr, END_IDX))
                blk_end <= req.wdata[7:0];
        end
    end
endmodule // ssop_regs

// ### sim/ssop_rx_model.sv
// Purpose: receiver model that samples the serial pins on the system clock
// Assumes: data is stable at the rising serial clock edge
// Notes: bits count only while ready is active; frames counted per sampled bit
`timescale 1ns/1ps
module ssop_rx_model (
    input  wire logic   clk,
    input  wire logic   clear,
    input  wire logic   sclk,
    input  wire logic   sdata,
    input  wire logic   frame,
    input  wire logic   ready,
    input  wire logic   fpol,
    input  wire logic   rpol,
    output logic [63:0] shift_reg,
    output logic [7:0]  bits_reg,
    output logic [7:0]  frames_reg,
    output logic [7:0]  rises_reg,
    output logic [3:0]  period_reg
);
    logic       sclk_reg;
    logic [3:0] gap_reg;
    logic       rise;

    // rising edge of the serial clock as seen by the system clock
    assign rise = sclk & ~sclk_reg;

    // edge finder and cycles between rising edges
    always_ff @(posedge clk) begin
        sclk_reg <= sclk;
        gap_reg  <= rise ? 4'h1 : gap_reg + 4'h1;
        if (rise) begin
            period_reg <= gap_reg;
        end
    end

    // capture on the rising edge, msb arrives first
    always_ff @(posedge clk) begin
        if (clear) begin
            shift_reg  <= 64'h0;
            bits_reg   <= 8'h00;
            frames_reg <= 8'h00;
            rises_reg  <= 8'h00;
        end else if (rise) begin
            rises_reg <= rises_reg + 8'h01;
            if (ready ^ rpol) begin
                shift_reg <= {shift_reg[62:0], sdata};
                bits_reg  <= bits_reg + 8'h01;
                if (frame ^ fpol) begin
                    frames_reg <= frames_reg + 8'h01;
                end
            end
        end
    end
endmodule // ssop_rx_model

// ### sim/sync_serial_output_port_test.sv
// Purpose: self-checking bench for the serial output port
// Assumes: memory answers the cycle after a read strobe
// Notes: each transfer sends two words, start 0x04 through end 0x05
`timescale 1ns/1ps
module sync_serial_output_port_test;
    import ssop_pkg::*;
    localparam logic [15:0] A_CTRL = {CTRL_IDX[13:0], 2'b00};
    localparam logic [15:0] A_BEG  = {BEG_IDX[13:0], 2'b00};
    localparam logic [15:0] A_END  = {END_IDX[13:0], 2'b00};
    localparam logic [15:0] A_STAT = {STATUS_IDX[13:0], 2'b00};
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic [15:0] avs_address = 16'h0000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        pass_start = 1'b0;
    logic        display_enable = 1'b0;
    logic [3:0]  seg_drive = 4'h0;
    logic [7:0]  mem_addr;
    logic        mem_rd;
    logic [31:0] mem_rdata = 32'h0;
    logic        pin_a, pin_b, pin_c, pin_d;
    logic        rx_clear = 1'b0;
    logic        fpol = 1'b0;
    logic        rpol = 1'b0;
    logic [63:0] rx_shift;
    logic [7:0]  rx_bits, rx_frames, rx_rises;
    logic [3:0]  rx_period;
    int          mem_reads = 0;
    int          err_total = 0;
    int          checks_done = 0;

    // word stored at each memory address
    function automatic logic [31:0] pat(input logic [7:0] a);
        return {a, 8'h5A, ~a, 8'hC3};
    endfunction

    // clock
    always #20 ref_clk = ~ref_clk;

    // memory answers next cycle, garbage otherwise; reads counted
    always @(posedge ref_clk) begin
        mem_rdata <= mem_rd ? pat(mem_addr) : ~mem_rdata;
        mem_reads <= rx_clear ? 0 : mem_reads + int'(mem_rd);
    end

    ssop_top dut (.REF_CLK(ref_clk), .SRST(srst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .PASS_START(pass_start),
        .DISPLAY_ENABLE(display_enable), .LCD_SEG_DRIVE(seg_drive), .MEM_ADDR(mem_addr),
        .MEM_RD(mem_rd), .MEM_RDATA(mem_rdata), .SEG_PIN_A(pin_a), .SEG_PIN_B(pin_b),
        .SEG_PIN_C(pin_c), .SEG_PIN_D(pin_d));

    ssop_rx_model rx (.clk(ref_clk), .clear(rx_clear), .sclk(pin_a), .sdata(pin_b), .frame(pin_c),
        .ready(pin_d), .fpol(fpol), .rpol(rpol), .shift_reg(rx_shift), .bits_reg(rx_bits),
        .frames_reg(rx_frames), .rises_reg(rx_rises), .period_reg(rx_period));

    // compare and count
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic [3:0] be,
                       output logic [31:0] rd);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] be);
        logic [31:0] unused;
        bus(1'b1, a, d, be, unused);
    endtask

    task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
        logic [31:0] got;
        bus(1'b0, a, 8'h00, 4'hF, got);
        check(what, {56'h0, exp}, {32'h0, got});
    endtask

    // one-cycle pulses
    task automatic clr();
        @(posedge ref_clk);
        rx_clear <= 1'b1;
        @(posedge ref_clk);
        rx_clear <= 1'b0;
    endtask

    task automatic start();
        @(posedge ref_clk);
        pass_start <= 1'b1;
        @(posedge ref_clk);
        pass_start <= 1'b0;
    endtask

    // reset values, masked write, read-only and unmapped places
    task automatic t_regs();
        rd_chk("ctrl reset", A_CTRL, CTRL_RST);
        rd_chk("start reset", A_BEG, BEG_RST);
        rd_chk("end reset", A_END, END_RST);
        wr(A_BEG, 8'h04, 4'hF);
        wr(A_END, 8'h77, 4'hE);
        rd_chk("end masked", A_END, 8'h00);
        wr(A_END, 8'h05, 4'h1);
        wr(A_STAT, 8'hFF, 4'hF);
        wr(16'h0100, 8'h33, 4'hF);
        rd_chk("start", A_BEG, 8'h04);
        rd_chk("end", A_END, 8'h05);
        rd_chk("status", A_STAT, 8'h00);
        rd_chk("unmapped", 16'h0100, 8'h00);
        $display("test regs done");
    endtask

    // pin sharing, gated and free serial clock
    task automatic t_pins();
        seg_drive <= 4'hA;
        repeat (3) @(posedge ref_clk);
        check("display pins", 64'hA, {pin_d, pin_c, pin_b, pin_a});
        wr(A_CTRL, 8'hA0, 4'h1);
        clr();
        repeat (40) @(posedge ref_clk);
        check("ready pin kept", 64'h1, pin_d);
        check("gated idle rises", 64'h0, rx_rises);
        check("gated idle clock", 64'h0, pin_a);
        display_enable <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("display wins", 64'hA, {pin_d, pin_c, pin_b, pin_a});
        display_enable <= 1'b0;
        wr(A_CTRL, 8'h80, 4'h1);
        repeat (20) @(posedge ref_clk);
        check("free clock period", 64'(SLOW_PERIOD), rx_period);
        $display("test pins done");
    endtask

    // one two-word block in a given mode
    task automatic t_block(input logic fast, input logic [1:0] sp, input logic fp, input logic rp);
        int n;
        fpol <= fp;
        rpol <= rp;
        wr(A_CTRL, {1'b1, fast, 1'b1, sp, fp, 1'b1, rp}, 4'h1);
        clr();
        repeat (4) @(posedge ref_clk);
        check("idle frame ready", {62'h0, fp, rp}, {pin_c, pin_d});
        start();
        rd_chk("busy status", A_STAT, 8'h03);
        for (n = 0; n < 4000 && rx_bits !== 8'd64; n++) @(posedge ref_clk);
        repeat (30) @(posedge ref_clk);
        check("block data", {pat(8'h04), pat(8'h05)}, rx_shift);
        check("bit count", 64'd64, rx_bits);
        check("frame pulses", (sp == 2'h0) ? 64'd1 : 64'd64 >> (sp + 3'd2), rx_frames);
        check("clock period", 64'(fast ? FAST_PERIOD : SLOW_PERIOD), rx_period);
        check("word reads", 64'd2, 64'(mem_reads));
        check("idle pins", {61'h0, 1'b0, fp, rp}, {pin_a, pin_c, pin_d});
        $display("test block spacing %0d done", sp);
    endtask

    // end not above start: nothing is sent
    task automatic t_refuse();
        wr(A_END, 8'h04, 4'h1);
        clr();
        start();
        repeat (300) @(posedge ref_clk);
        check("refused reads", 64'(mem_reads), 64'd0);
        check("refused bits", 64'd0, rx_bits);
        rd_chk("pending status", A_STAT, 8'h06);
        $display("test refuse done");
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        t_regs();
        t_pins();
        for (int sp = 0; sp < 4; sp++) begin
            t_block(sp[0], 2'(sp), sp[1], sp[0] ^ sp[1]);
        end
        t_refuse();
        report_and_stop();
    end

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        report_and_stop();
    end
endmodule // sync_serial_output_port_test
